/* File: dv/sfc_cmd_assertions.sv */
// Purpose: Port checks for the reset, sleep and wake command logic.
// Assumes: One clock domain; clock-enable pauses only stretch the counts.
// Notes: The wake period is counted in helper logic.
`timescale 1ns/1ps
`default_nettype none
module sfc_cmd_chk #(
   parameter int WAKE_CYC = 75
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic busy,
   input wire logic [7:0] nv_cfg_default,
   input wire logic hw_reset_n_pin,
   input wire logic cs_n_pin,
   input wire logic [3:0] io_oe_n,
   input wire logic soft_reset,
   input wire logic reset_armed,
   input wire logic asleep,
   input wire logic waking,
   input wire logic [7:0] cfg_vol,
   input wire logic volatile_status_protect_bit,
   input wire logic protection_lock_bit
);
   int wake_cnt_q;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // Counts cycles of the running wake period.
   always_ff @(posedge clk) begin
      if (waking)
         wake_cnt_q <= wake_cnt_q + 1;
      else
         wake_cnt_q <= 0;
   end
   chk_sr_needs_arm: assert property (soft_reset |-> $past(reset_armed))
      else $error("soft reset without arm");
   chk_sr_clears_arm: assert property (soft_reset |=> !reset_armed && !soft_reset)
      else $error("arm kept after soft reset");
   chk_sr_reload: assert property (soft_reset |-> ##[1:3] cfg_vol == nv_cfg_default)
      else $error("config not reloaded");
   chk_sr_keeps_prot: assert property (soft_reset ##3 1'b1 |->
      {volatile_status_protect_bit, protection_lock_bit} ==
      $past({volatile_status_protect_bit, protection_lock_bit}, 3))
      else $error("protect bits changed by soft reset");
   chk_no_arm_asleep: assert property ($rose(reset_armed) |-> !$past(asleep))
      else $error("armed while asleep");
   chk_hw_reset_wins: assert property (!hw_reset_n_pin [*5] |->
      !asleep && !reset_armed)
      else $error("hardware reset not honoured");
   chk_wake_time: assert property ($fell(waking) |-> wake_cnt_q >= WAKE_CYC && !asleep)
      else $error("wake period too short");
   chk_idle_hiz: assert property (cs_n_pin [*8] |-> io_oe_n == 4'hF)
      else $error("lanes driven while deselected");
   chk_busy_no_wake: assert property (busy |-> !$rose(waking))
      else $error("wake taken while busy");
endmodule
bind sfc_cmd_top sfc_cmd_chk #(.WAKE_CYC(WAKE_CYC)) chk_u (.clk(clk), .rstn(rstn),
   .busy(busy), .nv_cfg_default(nv_cfg_default), .hw_reset_n_pin(hw_reset_n_pin),
   .cs_n_pin(cs_n_pin), .io_oe_n(io_oe_n), .soft_reset(soft_reset),
   .reset_armed(reset_armed), .asleep(asleep), .waking(waking), .cfg_vol(cfg_vol),
   .volatile_status_protect_bit(volatile_status_protect_bit),
   .protection_lock_bit(protection_lock_bit));
`default_nettype wire

/* File: dv/sfc_host_model.sv */
// Purpose: Host controller model that frames commands for the flash logic.
// Assumes: Mode 0 clocking, five clk cycles per serial clock phase.
// Notes: Lanes are inverted at frame end, so stale bits never look valid.
`timescale 1ns/1ps
`default_nettype none
module sfc_host_model (
   input wire logic clk,
   input wire logic quad,
   input wire logic [3:0] io_in,
   output logic cs_n,
   output logic sck,
   output logic [3:0] io
);
   // Idle bus at time zero.
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      io = 4'h0;
   end
   // Waits n edges, then steps just past the last one.
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Shifts n serial clocks from tx, MSB first, keeping the last byte read.
   task automatic frame(input logic [63:0] tx, input int n, output logic [7:0] rd);
      logic [63:0] sh;
      sh = tx;
      rd = 8'h00;
      cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         if (quad) begin
            io = sh[63:60];
            sh = sh << 4;
         end else begin
            io = {3'h5, sh[63]};
            sh = sh << 1;
         end
         wt(5);
         sck = 1'b1;
         rd = quad ? {rd[3:0], io_in} : {rd[6:0], io_in[1]};
         wt(5);
         sck = 1'b0;
      end
      wt(5);
      cs_n = 1'b1;
      io = ~io;
      wt(8);
   endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Purpose: Self-checking bench for the reset, sleep, wake and parameter read commands.
// Assumes: Short sleep and wake counts are set through parameters.
// Notes: Lane levels are resolved from the DUT's output enables alone; the host always drives.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic quad = 1'b0;
   logic busy = 1'b0;
   logic xip_enter = 1'b0;
   logic [7:0] nv_cfg = 8'h3C;
   logic srp_set = 1'b0;
   logic lock_clear = 1'b0;
   logic hw_n = 1'b1;
   logic ce = 1'b1;
   logic lock_por = 1'b1;
   logic cs_n, sck, soft_reset, reset_armed, asleep, waking, xip_active, vsp, plb;
   logic [3:0] h_io, io_o, io_oe_n;
   logic [7:0] cfg_vol, rd;
   logic [7:0] sr_cnt = 8'h00;
   wire logic [3:0] io_w;
   int errors = 0;
   int samples_checked = 0;
   assign io_w = (io_oe_n & h_io) | (~io_oe_n & io_o);
   always #20 clk = ~clk;
   // Counts executed software resets.
   always @(posedge clk) if (soft_reset === 1'b1) sr_cnt <= sr_cnt + 8'h01;
   sfc_host_model host_u (.clk(clk), .quad(quad), .io_in(io_w), .cs_n(cs_n), .sck(sck),
      .io(h_io));
   sfc_cmd_top #(.SLEEP_ENTRY_CYC(4), .WAKE_CYC(12), .TABLE({8'hA5, 120'h0})) dut_u (
      .clk(clk), .rstn(rstn), .ce(ce), .quad_instruction_mode(quad), .busy(busy),
      .xip_enter(xip_enter), .nv_cfg_default(nv_cfg), .lock_por_value(lock_por),
      .srp_set(srp_set), .lock_clear(lock_clear), .hw_reset_n_pin(hw_n), .cs_n_pin(cs_n),
      .sck_pin(sck), .io_i(io_w), .io_o(io_o), .io_oe_n(io_oe_n), .soft_reset(soft_reset),
      .reset_armed(reset_armed), .asleep(asleep), .waking(waking), .xip_active(xip_active),
      .cfg_vol(cfg_vol), .volatile_status_protect_bit(vsp), .protection_lock_bit(plb));
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask
   task automatic complete_run();
      $display("checked=%0d errors=%0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic t_xip();
      xip_enter = 1'b1;
      host_u.wt(1);
      xip_enter = 1'b0;
      host_u.frame({8'h66, 56'h0}, 8, rd);
      chk_bit(reset_armed, 1'b0);
      host_u.frame({8'hFF, 56'h0}, 8, rd);
      chk_bit(xip_active, 1'b0);
      host_u.frame({8'h66, 56'h0}, 8, rd);
      chk_bit(reset_armed, 1'b1);
      $display("test xip done");
   endtask
   task automatic t_disarm();
      host_u.frame({8'h5A, 56'h0}, 48, rd);
      chk_byte(rd, 8'h53);
      chk_bit(reset_armed, 1'b0);
      host_u.frame({8'h99, 56'h0}, 8, rd);
      chk_byte(sr_cnt, 8'h00);
      host_u.frame({8'h5A, 24'h000300, 32'h0}, 48, rd);
      chk_byte(rd, 8'hA5);
      host_u.frame({8'h5A, 24'h000010, 32'h0}, 48, rd);
      chk_byte(rd, 8'hFF);
      $display("test disarm done");
   endtask
   task automatic t_reset();
      srp_set = 1'b1;
      lock_clear = 1'b1;
      nv_cfg = 8'hC3;
      host_u.wt(1);
      srp_set = 1'b0;
      lock_clear = 1'b0;
      host_u.frame({8'h66, 56'h0}, 8, rd);
      chk_bit(reset_armed, 1'b1);
      // A frame sent while the clock enable is low must leave no trace.
      ce = 1'b0;
      host_u.frame({8'h99, 56'h0}, 8, rd);
      ce = 1'b1;
      chk_bit(reset_armed, 1'b1);
      chk_byte(sr_cnt, 8'h00);
      host_u.frame({8'h99, 56'h0}, 8, rd);
      chk_byte(sr_cnt, 8'h01);
      chk_byte(cfg_vol, 8'hC3);
      chk_byte({6'h0, vsp, plb}, 8'h02);
      $display("test reset done");
   endtask
   task automatic t_sleep();
      host_u.frame({8'hB9, 56'h0}, 9, rd);
      chk_bit(asleep, 1'b0);
      host_u.frame({8'hB9, 56'h0}, 8, rd);
      chk_bit(asleep, 1'b1);
      host_u.frame({8'h66, 56'h0}, 8, rd);
      chk_bit(reset_armed, 1'b0);
      busy = 1'b1;
      host_u.frame({8'hAB, 56'h0}, 8, rd);
      chk_byte({6'h0, asleep, waking}, 8'h02);
      busy = 1'b0;
      host_u.frame({8'hAB, 56'h0}, 8, rd);
      chk_bit(waking, 1'b1);
      host_u.wt(12);
      chk_byte({6'h0, asleep, waking}, 8'h00);
      host_u.frame({8'hB9, 56'h0}, 8, rd);
      hw_n = 1'b0;
      host_u.wt(8);
      hw_n = 1'b1;
      host_u.wt(6);
      chk_byte({5'h00, asleep, vsp, plb}, 8'h01);
      $display("test sleep done");
   endtask
   task automatic t_id();
      host_u.frame({8'hAB, 56'h0}, 40, rd);
      chk_byte(rd, 8'h5C);
      quad = 1'b1;
      host_u.frame({8'hAB, 56'h0}, 10, rd);
      chk_byte(rd, 8'h5C);
      host_u.frame({8'h66, 56'h0}, 2, rd);
      chk_bit(reset_armed, 1'b1);
      quad = 1'b0;
      $display("test id done");
   endtask
   // Main sequence.
   initial begin
      host_u.wt(2);
      rstn = 1'b1;
      host_u.wt(6);
      t_xip();
      t_disarm();
      t_reset();
      t_sleep();
      t_id();
      complete_run();
   end
   // Cuts a hang short.
   initial begin
      #1000000;
      errors++;
      $display("watchdog expired");
      complete_run();
   end
endmodule
`default_nettype wire

/* File: hdl/sfc_cmd_top.sv */
// Purpose: Decodes reset, mode clear, sleep, wake/ID and parameter read commands.
// Assumes: Serial clock runs at most one eighth of clk; other commands decode elsewhere.
// Notes: All pins are synchronised, so answers trail the serial edges by a few clk cycles.
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defines.svh"
module sfc_cmd_top #(
   parameter logic [7:0] DEVICE_ID = 8'h5C, // Arbitrary value.
   parameter int SLEEP_ENTRY_CYC = `SFC_SLEEP_ENTRY_CYC,
   parameter int WAKE_CYC = `SFC_WAKE_CYC,
   parameter logic [63:0] HEADER = 64'h5346445006010100,
   parameter logic [127:0] TABLE = 128'h0
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic quad_instruction_mode,
   input wire logic busy,
   input wire logic xip_enter,
   input wire logic [7:0] nv_cfg_default,
   input wire logic lock_por_value,
   input wire logic srp_set,
   input wire logic lock_clear,
   input wire logic hw_reset_n_pin,
   input wire logic cs_n_pin,
   input wire logic sck_pin,
   input wire logic [3:0] io_i,
   output logic [3:0] io_o,
   output logic [3:0] io_oe_n,
   output logic soft_reset,
   output logic reset_armed,
   output logic asleep,
   output logic waking,
   output logic xip_active,
   output logic [7:0] cfg_vol,
   output logic volatile_status_protect_bit,
   output logic protection_lock_bit
);
   localparam logic [11:0] SLEEP_CNT = 12'(SLEEP_ENTRY_CYC < 1 ? 1 : SLEEP_ENTRY_CYC);
   localparam logic [11:0] WAKE_CNT = 12'(WAKE_CYC < 1 ? 1 : WAKE_CYC);

   // Advances a bit counter by one lane or four.
   function automatic logic [4:0] adv(input logic [4:0] c, input logic quad);
      adv = quad ? c + 5'h04 : c + 5'h01;
   endfunction

   // Shifts one or four input bits into a shift register, first bit most significant.
   function automatic logic [23:0] shin(input logic [23:0] sh, input logic [3:0] d,
                                        input logic quad);
      shin = quad ? {sh[19:0], d} : {sh[22:0], d[0]};
   endfunction

   logic hw_rst_n_s;
   logic cs_n_s;
   logic sck_s;
   logic [3:0] io_s;
   logic cs_d_q;
   logic sck_d_q;
   logic por;
   logic cs_rise;
   logic cs_fall;
   logic sck_rise;
   logic sck_fall;
   logic quad_w;
   logic [23:0] instr_sh;
   logic [7:0] op_next;
   logic [4:0] cnt_next;
   logic [23:0] addr_sh;
   logic instr_end;
   logic allow_wake;
   logic allow_param;
   logic allow_other;
   logic exec;
   logic [7:0] next_byte;
   logic [7:0] rom_byte;
   logic [7:0] cur_byte;
   logic byte_wrap;
   logic [2:0] ocnt_next;
   logic [7:0] shift_out;

   sfc_pkg::sfc_state_t st_q;
   sfc_pkg::sfc_cmd_t cmd_q;
   logic [7:0] op_q;
   logic [4:0] cnt_q;
   logic [4:0] dummy_q;
   logic [2:0] ocnt_q;
   logic [7:0] out_q;
   logic [23:0] addr_q;
   logic done_q;
   logic had_cmd_q;
   logic entering_q;
   logic [11:0] tmr_q;
   logic reload_q;
   logic por_load_q;

   // Hardware reset, select, clock and data pins cross into clk here.
   sfc_sync #(.W(7), .RST_VAL(7'h60)) u_sync (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .d({hw_reset_n_pin, cs_n_pin, sck_pin, io_i}),
      .q({hw_rst_n_s, cs_n_s, sck_s, io_s})
   );

   sfc_param_rom #(.HEADER(HEADER), .TABLE(TABLE)) u_rom (
      .addr(addr_q),
      .data(rom_byte)
   );

   // While the clock enable is high, a hardware reset acts as a full power-on reset in every state, asleep included. [RULE10]
   assign por = !rstn || (ce && !hw_rst_n_s);

   // Edge detection works on the synchronised copies only.
   assign cs_rise = cs_n_s && !cs_d_q;
   assign cs_fall = !cs_n_s && cs_d_q;
   assign sck_rise = sck_s && !sck_d_q && !cs_n_s;
   assign sck_fall = !sck_s && sck_d_q && !cs_n_s;

   // Quad mode puts instruction and ID on all lanes. [RULE15]
   // In continuous read only lane 0 counts, so the other lanes are ignored. [RULE5]
   assign quad_w = quad_instruction_mode && !xip_active;
   assign instr_sh = shin({16'h0000, op_q}, io_s, quad_w);
   assign op_next = instr_sh[7:0];
   assign cnt_next = adv(cnt_q, quad_w);
   assign addr_sh = shin(addr_q, io_s, quad_w);
   assign instr_end = (st_q == sfc_pkg::SFC_ST_INSTR) && !done_q && (cnt_next == `SFC_INSTR_BITS);

   // Asleep only wake is seen, and busy blocks wake. [RULE9] [RULE14]
   // Continuous read sees only mode clear. [RULE4]
   assign allow_wake = (op_next == `SFC_OP_WAKE_ID) && !busy && !xip_active;
   assign allow_param = (op_next == `SFC_OP_PARAM_READ) && !asleep && !xip_active; // [RULE16]
   assign allow_other = xip_active ? (op_next == `SFC_OP_MODE_CLEAR) : !asleep;

   // A short command executes only when select rises right after bit eight. [RULE7]
   assign exec = cs_rise && (st_q == sfc_pkg::SFC_ST_INSTR) && done_q;

   // Output path: a new byte is fetched whenever the bit counter wraps.
   assign next_byte = (cmd_q == sfc_pkg::SFC_CMD_ID) ? DEVICE_ID : rom_byte;
   assign cur_byte = (ocnt_q == 3'h0) ? next_byte : out_q;
   assign ocnt_next = quad_w ? ocnt_q + 3'h4 : ocnt_q + 3'h1;
   assign byte_wrap = (ocnt_next == 3'h0);
   assign shift_out = quad_w ? {cur_byte[3:0], 4'h0} : {cur_byte[6:0], 1'b0};

   // Pin edge history.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cs_d_q <= 1'b1;
         sck_d_q <= 1'b0;
      end else if (ce) begin
         cs_d_q <= cs_n_s;
         sck_d_q <= sck_s;
      end
   end

   // Frame sequencer: instruction, address, dummy and data phases.
   always_ff @(posedge clk) begin
      if (por) begin
         st_q <= sfc_pkg::SFC_ST_IGNORE;
         cmd_q <= sfc_pkg::SFC_CMD_NONE;
         op_q <= 8'h00;
         cnt_q <= 5'h00;
         dummy_q <= 5'h00;
         addr_q <= 24'h000000;
         done_q <= 1'b0;
         had_cmd_q <= 1'b0;
      end else if (ce) begin
         if (cs_fall) begin
            st_q <= waking ? sfc_pkg::SFC_ST_IGNORE : sfc_pkg::SFC_ST_INSTR; // [RULE11]
            cmd_q <= sfc_pkg::SFC_CMD_NONE;
            cnt_q <= 5'h00;
            done_q <= 1'b0;
            had_cmd_q <= 1'b0;
         end else if (sck_rise) begin
            case (st_q)
               sfc_pkg::SFC_ST_INSTR: begin
                  op_q <= op_next;
                  cnt_q <= cnt_next;
                  if (done_q) begin
                     st_q <= sfc_pkg::SFC_ST_IGNORE; // Extra clocks cancel a short command. [RULE7]
                  end else if (instr_end) begin
                     had_cmd_q <= !xip_active && !asleep;
                     cnt_q <= 5'h00;
                     if (allow_wake) begin
                        cmd_q <= sfc_pkg::SFC_CMD_ID;
                        st_q <= sfc_pkg::SFC_ST_DUMMY;
                        dummy_q <= quad_w ? `SFC_ID_DUMMY_CLKS_QUAD :
                                   `SFC_ID_DUMMY_CLKS_SINGLE; // [RULE12]
                     end else if (allow_param) begin
                        cmd_q <= sfc_pkg::SFC_CMD_PARAM;
                        st_q <= sfc_pkg::SFC_ST_ADDR;
                     end else if (allow_other && (op_next != `SFC_OP_WAKE_ID)) begin
                        done_q <= 1'b1;
                     end else begin
                        st_q <= sfc_pkg::SFC_ST_IGNORE; // [RULE9] [RULE14]
                     end
                  end
               end
               sfc_pkg::SFC_ST_ADDR: begin
                  addr_q <= addr_sh;
                  cnt_q <= cnt_next;
                  if (cnt_next == `SFC_ADDR_BITS) begin
                     st_q <= sfc_pkg::SFC_ST_DUMMY;
                     dummy_q <= `SFC_PARAM_DUMMY_CLKS;
                  end
               end
               sfc_pkg::SFC_ST_DUMMY: begin
                  dummy_q <= dummy_q - 5'h01;
                  if (dummy_q == 5'h01) begin
                     st_q <= sfc_pkg::SFC_ST_DATA;
                  end
               end
               sfc_pkg::SFC_ST_DATA: begin
                  st_q <= sfc_pkg::SFC_ST_DATA;
               end
               default: begin
                  st_q <= sfc_pkg::SFC_ST_IGNORE;
               end
            endcase
         end else if (sck_fall && (st_q == sfc_pkg::SFC_ST_DATA) && byte_wrap &&
                      (cmd_q == sfc_pkg::SFC_CMD_PARAM)) begin
            addr_q <= addr_q + 24'h000001; // Parameter reads walk forward byte by byte.
         end
      end
   end

   // Read data leaves on falling serial edges, MSB first. [RULE12]
   // The ID simply repeats past its end. [RULE13]
   always_ff @(posedge clk) begin
      if (por) begin
         io_o <= 4'h0;
         io_oe_n <= 4'hF;
         out_q <= 8'h00;
         ocnt_q <= 3'h0;
      end else if (ce) begin
         if (cs_rise || cs_fall) begin
            io_oe_n <= 4'hF; // [RULE13]
            ocnt_q <= 3'h0;
         end else if (sck_fall && (st_q == sfc_pkg::SFC_ST_DATA)) begin
            io_o <= quad_w ? cur_byte[7:4] : {2'b00, cur_byte[7], 1'b0}; // [RULE15]
            io_oe_n <= quad_w ? 4'h0 : 4'hD;
            out_q <= shift_out;
            ocnt_q <= ocnt_next;
         end
      end
   end

   // Reset arming, software reset, continuous read and the sleep/wake timer.
   always_ff @(posedge clk) begin
      if (por) begin
         reset_armed <= 1'b0;
         soft_reset <= 1'b0;
         xip_active <= 1'b0;
         asleep <= 1'b0;
         waking <= 1'b0;
         entering_q <= 1'b0;
         tmr_q <= 12'h000;
      end else if (ce) begin
         soft_reset <= exec && (op_q == `SFC_OP_RESET_EXEC) && reset_armed; // [RULE3] [RULE1]
         if (exec && (op_q == `SFC_OP_RESET_ARM) && had_cmd_q) begin
            reset_armed <= 1'b1; // [RULE1]
         end else if (cs_rise && had_cmd_q) begin
            reset_armed <= 1'b0; // [RULE2]
         end
         if (xip_enter) begin
            xip_active <= 1'b1; // Entry wins over a clear in the same cycle.
         end else if (exec && (op_q == `SFC_OP_MODE_CLEAR)) begin
            xip_active <= 1'b0; // [RULE4]
         end
         if (exec && (op_q == `SFC_OP_SLEEP) && !asleep && !entering_q) begin
            entering_q <= 1'b1; // [RULE7]
            tmr_q <= SLEEP_CNT;
         end else if (cs_rise && asleep && (cmd_q == sfc_pkg::SFC_CMD_ID)) begin
            waking <= 1'b1; // [RULE11]
            tmr_q <= WAKE_CNT;
         end else if (tmr_q != 12'h000) begin
            tmr_q <= tmr_q - 12'h001;
            if (tmr_q == 12'h001) begin
               asleep <= entering_q; // [RULE8]
               entering_q <= 1'b0;
               waking <= 1'b0; // [RULE11]
            end
         end
      end
   end

   // Volatile configuration reloads after power-on or software reset.
   // Protect and lock reload only on power-on, so software reset cannot unlock them.
   always_ff @(posedge clk) begin
      if (por) begin
         cfg_vol <= `SFC_CFG_RESET;
         reload_q <= 1'b1;
         por_load_q <= 1'b1;
         volatile_status_protect_bit <= 1'b0;
         protection_lock_bit <= 1'b0;
      end else if (ce) begin
         reload_q <= soft_reset;
         por_load_q <= 1'b0;
         if (reload_q) begin
            cfg_vol <= nv_cfg_default; // [RULE19]
         end
         if (por_load_q) begin
            protection_lock_bit <= lock_por_value; // [RULE20]
         end else if (lock_clear) begin
            protection_lock_bit <= 1'b0;
         end
         if (srp_set) begin
            volatile_status_protect_bit <= 1'b1; // Software reset never touches this. [RULE20]
         end
      end
   end
endmodule
`default_nettype wire

/* File: hdl/sfc_param_rom.sv */
// Purpose: Factory-set discoverable parameter space, header and first table.
// Assumes: Contents are fixed at build time through parameters.
// Notes: There is no write path at all, so the host can never alter it.
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defines.svh"
module sfc_param_rom #(
   parameter logic [63:0] HEADER = 64'h5346445006010100,
   parameter logic [127:0] TABLE = 128'h0
) (
   input wire logic [23:0] addr,
   output logic [7:0] data
);
   logic in_hdr;
   logic in_tbl;
   logic [23:0] tbl_off;
   logic [7:0] hdr_byte;
   logic [7:0] tbl_byte;

   // Header spans eight bytes, the table sixteen; all else reads undefined. [RULE17]
   assign tbl_off = addr - `SFC_TBL_BASE;
   assign in_hdr = (addr - `SFC_HDR_BASE) < 24'h000008;
   assign in_tbl = (addr >= `SFC_TBL_BASE) && (tbl_off < 24'h000010);
   assign hdr_byte = HEADER[{3'h7 - addr[2:0], 3'h0} +: 8];
   assign tbl_byte = TABLE[{4'hF - tbl_off[3:0], 3'h0} +: 8];
   assign data = in_hdr ? hdr_byte : (in_tbl ? tbl_byte : `SFC_UNDEF_BYTE); // [RULE18]
endmodule
`default_nettype wire

/* File: hdl/sfc_sync.sv */
// Purpose: Two-stage synchroniser for pins entering the clock domain.
// Assumes: Inputs are quasi-static relative to clk.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
`default_nettype none
module sfc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   // The first stage feeds the second stage and nothing else.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end else if (ce) begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule
`default_nettype wire

/* File: pkg/sfc_defines.svh */
// Purpose: Shared constants for the serial flash reset, sleep and identification command logic.
// Assumes: A 25 MHz system clock samples the serial pins.
// Notes: Functional notes follow. Times are in ns; cycle counts derive from them.
// Functional notes
// RULE1: Reset needs arm then execute, in order.
// RULE2: Any other command after arm disarms it.
// RULE3: Execute directly after arm starts software reset.
// RULE4: Mode-bit clear leaves continuous read mode.
// RULE5: Host sends ones on lane 0, eight clocks.
// RULE6: Host sends mode-bit clear after system reset.
// RULE7: Sleep needs select rise right after bit eight.
// RULE8: Sleep state reached within sleep entry time.
// RULE9: Asleep, only wake/ID command is recognised.
// RULE10: Hardware reset always honoured, even while asleep; the code ignores it while the clock enable is low.
// RULE11: Wake needs select high for wake time.
// RULE12: ID, MSB first, falling edge, after 3 dummies.
// RULE13: Beyond ID is undefined; select rise ends read.
// RULE14: Wake/ID ignored while device is busy.
// RULE15: Quad instruction mode uses all four lanes.
// RULE16: Parameter read uses separate address space.
// RULE17: Header at 0000h, table at 0300h, gaps undefined.
// RULE18: Parameter space is read-only to host.
// RULE19: Software reset reloads volatile registers from defaults.
// RULE20: Software reset keeps protect and lock bits.
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH

`define SFC_OP_RESET_ARM 8'h66
`define SFC_OP_RESET_EXEC 8'h99
`define SFC_OP_MODE_CLEAR 8'hFF
`define SFC_OP_SLEEP 8'hB9
`define SFC_OP_WAKE_ID 8'hAB
`define SFC_OP_PARAM_READ 8'h5A

`define SFC_INSTR_BITS 5'h08
`define SFC_ADDR_BITS 5'h18
`define SFC_ID_DUMMY_CLKS_SINGLE 5'h18
`define SFC_ID_DUMMY_CLKS_QUAD 5'h06
`define SFC_PARAM_DUMMY_CLKS 5'h08

`define SFC_HDR_BASE 24'h000000
`define SFC_TBL_BASE 24'h000300
`define SFC_UNDEF_BYTE 8'hFF
`define SFC_CFG_RESET 8'h00

`define SFC_CLK_NS 40
`define SFC_SLEEP_ENTRY_NS 3000
`define SFC_WAKE_NS 3000
`define SFC_SLEEP_ENTRY_CYC (`SFC_SLEEP_ENTRY_NS / `SFC_CLK_NS)
`define SFC_WAKE_CYC ((`SFC_WAKE_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS)

`endif

/* File: pkg/sfc_pkg.sv */
// Purpose: Types for the serial flash command logic.
// Assumes: Constants live in sfc_defines.svh.
// Notes: Binary state codes are written out.
`default_nettype none
package sfc_pkg;

   typedef enum logic [2:0] {
      SFC_ST_INSTR  = 3'h0,
      SFC_ST_ADDR   = 3'h1,
      SFC_ST_DUMMY  = 3'h2,
      SFC_ST_DATA   = 3'h3,
      SFC_ST_IGNORE = 3'h4
   } sfc_state_t;

   typedef enum logic [1:0] {
      SFC_CMD_NONE  = 2'h0,
      SFC_CMD_ID    = 2'h1,
      SFC_CMD_PARAM = 2'h2
   } sfc_cmd_t;

endpackage
`default_nettype wire
